// *** design/flash_addr_error_protect.sv ***
// flash program address, error flags and protection enforcement
// Operation
// - error register updates when bank-0 busy clears
// - write-error flag set on write fault or bad setup, held till cleared
// - erase-error flag set on erase failure, software clear only
// - program-error flag set on program failure, software clear only
// - overwrite-error flag set on one-over-zero, not for protection bits
// - bad register combination sets sequence error and blocks the write
// - bad resume sets resume error and aborts the suspended operation
// - write-protect hit sets flag; unprotected sectors of a multi-erase proceed
// - protection cells read once at reset into four volatile registers
// - all protection fuses read zero (protected) until the cells have been read
// - set protection accepted once the cells are read, unless code executes from the flash
// - four one-time-programmable protection registers, one write, three access
// - sector write blocked while its write-protect bit reads zero
// - access fuse zero blocks data access unless fetched from flash
// - debug fuse one lets debug bypass; zero disables debug and test modes
// - access protection enforced only when fuse and unprotect bit both zero
// - protected read from outside flash returns dummy data and trap 0x009B
`timescale 1ns/100ps
module flash_addr_error_protect
    import flash_prot_pkg::*;
(
    input  wire logic                 ref_clk_in,
    input  wire logic                 rst_in,
    // register port
    input  wire logic [ADDR_W-1:0]    reg_addr_in,
    input  wire logic [DATA_W-1:0]    reg_wdata_in,
    input  wire logic                 reg_write_in,
    input  wire logic                 reg_read_in,
    output logic      [DATA_W-1:0]    reg_rdata_out,
    // sequencer side
    input  wire logic                 bank0_busy_flag_in,
    input  wire fault_events_s        faults_in,
    input  wire write_req_s           write_req_in,
    input  wire logic                 suspend_active_in,
    input  wire logic                 set_protection_in,
    input  wire logic [1:0]           set_prot_reg_in,
    input  wire logic [15:0]          set_prot_data_in,
    input  wire logic                 exec_from_flash_in,
    input  wire data_access_s         access_in,
    input  wire logic                 temporary_unprotect_bit_in,
    // nonvolatile cell array
    input  wire logic [NUM_PREG*16-1:0] nv_cells_in,
    input  wire logic                 nv_ready_in,
    // results
    output logic [NUM_SECT-1:0]       sector_go_out,
    output logic                      write_go_out,
    output logic                      abort_suspended_out,
    output logic                      access_block_out,
    output logic                      trap_out,
    output logic [15:0]               trap_vector_out,
    output logic                      debug_enable_out,
    output logic                      prot_loaded_out
);

    logic [15:0] program_address_low;
    logic [15:0] program_address_high;
    logic [15:0] flash_error_flags;
    logic [15:0] pending;
    logic [15:0] next_address_low;
    logic [15:0] next_address_high;
    logic [15:0] next_error_flags;
    logic [15:0] next_pending;
    logic [15:0] next_rdata;
    logic [15:0] rdata;
    logic        busy_q;
    logic        sync_busy0;
    logic        sync_busy1;
    logic        sync_tau0;
    logic        sync_tau1;

    logic [NUM_PREG*16-1:0] prot_regs;
    logic [NUM_PREG-1:0]    set_sel;
    logic                   loaded;
    logic [15:0]            sector_write_protect_fuses;
    logic [15:0]            access_protect_fuses;
    logic [15:0]            ap1_low;
    logic [15:0]            ap1_high;
    logic [15:0]            event_bits;
    logic                   busy_fall;
    logic                   prot_active;
    logic [NUM_SECT-1:0]    sector_hit;

    logic [NUM_SECT-1:0]    next_sector_go;
    logic                   next_write_go;
    logic                   next_abort;
    logic                   next_block;
    logic                   next_trap;
    logic                   next_debug;
    logic [NUM_SECT-1:0]    sector_go;
    logic                   write_go;
    logic                   abort_q;
    logic                   block_q;
    logic                   trap_q;
    logic                   debug_q;
    logic [15:0]            next_trap_vec;
    logic [15:0]            trap_vec_q;

    // set protection only from outside the flash
    always_comb begin
        set_sel = '0;
        if (set_protection_in && !exec_from_flash_in) begin
            set_sel[set_prot_reg_in] = 1'b1;
        end
    end

    fuse_loader u_fuse_loader (
        .ref_clk_in    (ref_clk_in),
        .rst_in        (rst_in),
        .nv_cells_in   (nv_cells_in),
        .nv_ready_in   (nv_ready_in),
        .set_prot_in   (set_sel),
        .set_data_in   (set_prot_data_in),
        .prot_regs_out (prot_regs),
        .loaded_out    (loaded)
    );

    assign sector_write_protect_fuses = prot_regs[0*16 +: 16];
    assign access_protect_fuses       = prot_regs[1*16 +: 16];
    assign ap1_low                    = prot_regs[2*16 +: 16];
    assign ap1_high                   = prot_regs[3*16 +: 16];

    // busy and unprotect arrive from other logic blocks via pins
    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            sync_busy0 <= 1'b0;
            sync_busy1 <= 1'b0;
            sync_tau0  <= 1'b0;
            sync_tau1  <= 1'b0;
            busy_q     <= 1'b0;
        end else begin
            sync_busy0 <= bank0_busy_flag_in;
            sync_busy1 <= sync_busy0;
            sync_tau0  <= temporary_unprotect_bit_in;
            sync_tau1  <= sync_tau0;
            busy_q     <= sync_busy1;
        end
    end

    assign busy_fall = busy_q && !sync_busy1;

    // zero fuse means protected; before loading every sector is protected
    always_comb begin
        for (int s = 0; s < NUM_SECT; s++) begin
            sector_hit[s] = write_req_in.sectors[s]
                          && !sector_write_protect_fuses[s];
        end
    end

    // unprotect is synchronised, so it takes effect two cycles late
    assign prot_active = !access_protect_fuses[ACCESS_PROTECT_FUSE_BIT]
                       && !sync_tau1;

    // fault events collected while busy, posted when busy falls
    always_comb begin
        event_bits = ZERO16;
        event_bits[ERR_BIT]  = faults_in.write_fault
                             || (write_req_in.valid
                                 && !write_req_in.setup_ok);
        event_bits[ERASE_ERROR_FLAG_BIT] = faults_in.erase_fail;
        event_bits[PROGRAM_ERROR_FLAG_BIT] = faults_in.program_fail;
        event_bits[OVWR_BIT] = faults_in.overwrite
                             && !faults_in.protect_prog;
        event_bits[SEQ_BIT]  = faults_in.bad_sequence
                             || (write_req_in.valid
                                 && !write_req_in.setup_ok);
        event_bits[RES_BIT]  = faults_in.bad_resume
                             && suspend_active_in;
        event_bits[WPF_BIT]  = write_req_in.valid
                             && write_req_in.setup_ok
                             && (|sector_hit);
    end

    // program address registers; reserved bits always hold zero
    always_comb begin
        next_address_low  = program_address_low;
        next_address_high = program_address_high;
        if (reg_write_in && (reg_addr_in == REG_ADDR_LOW)) begin
            next_address_low = reg_wdata_in & ADDR_LOW_MASK;
        end
        if (reg_write_in && (reg_addr_in == REG_ADDR_HIGH)) begin
            next_address_high = reg_wdata_in & ADDR_HIGH_MASK;
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            program_address_low  <= ZERO16;
            program_address_high <= ZERO16;
        end else begin
            program_address_low  <= next_address_low;
            program_address_high <= next_address_high;
        end
    end

    // error flags: writing zero clears a flag, one leaves it
    always_comb begin
        next_error_flags = flash_error_flags;
        next_pending     = pending | event_bits;
        if (reg_write_in && (reg_addr_in == REG_ERROR)) begin
            next_error_flags = flash_error_flags & reg_wdata_in;
        end
        if (busy_fall) begin
            // posting wins over a clear in the same cycle
            next_error_flags = next_error_flags
                             | (next_pending & ERROR_MASK);
            next_pending     = ZERO16;
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            flash_error_flags <= ZERO16;
            pending           <= ZERO16;
        end else begin
            flash_error_flags <= next_error_flags;
            pending           <= next_pending;
        end
    end

    // read data stands for the one cycle after the strobe, zero otherwise
    always_comb begin
        next_rdata = ZERO16;
        if (reg_read_in) begin
            unique case (reg_addr_in)
                REG_ADDR_LOW:  next_rdata = program_address_low;
                REG_ADDR_HIGH: next_rdata = program_address_high;
                REG_ERROR:     next_rdata = flash_error_flags;
                REG_WP_FUSES:  next_rdata = sector_write_protect_fuses
                                          & WP_MASK;
                REG_AP_FUSES:  next_rdata = access_protect_fuses;
                REG_AP1_LOW:   next_rdata = ap1_low;
                REG_AP1_HIGH:  next_rdata = ap1_high;
                REG_STATUS:    next_rdata = {14'h0000, prot_active, loaded};
                default:       next_rdata = ZERO16;
            endcase
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            rdata <= ZERO16;
        end else begin
            rdata <= next_rdata;
        end
    end

    // gating of writes, accesses and debug
    always_comb begin
        next_write_go  = write_req_in.valid && write_req_in.setup_ok
                       && !faults_in.bad_sequence;
        next_sector_go = '0;
        if (next_write_go) begin
            next_sector_go = write_req_in.sectors & ~sector_hit;
        end
        next_abort = faults_in.bad_resume && suspend_active_in;
        next_block = access_in.valid && prot_active
                   && !access_in.fetch_from_flash;
        next_trap  = next_block && !access_in.is_write;
        next_trap_vec = next_trap ? TRAP_VECTOR : DUMMY_DATA;
        next_debug = loaded
                   && access_protect_fuses[DEBUG_PROTECT_FUSE_BIT];
    end

    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            sector_go <= '0;
            write_go  <= 1'b0;
            abort_q   <= 1'b0;
            block_q   <= 1'b0;
            trap_q    <= 1'b0;
            trap_vec_q <= DUMMY_DATA;
            debug_q   <= 1'b0;
        end else begin
            sector_go <= next_sector_go;
            write_go  <= next_write_go;
            abort_q   <= next_abort;
            block_q   <= next_block;
            trap_q    <= next_trap;
            trap_vec_q <= next_trap_vec;
            debug_q   <= next_debug;
        end
    end

    assign reg_rdata_out       = rdata;
    assign sector_go_out       = sector_go;
    assign write_go_out        = write_go;
    assign abort_suspended_out = abort_q;
    assign access_block_out    = block_q;
    assign trap_out            = trap_q;
    // a vector only accompanies the trap pulse
    assign trap_vector_out     = trap_vec_q;
    assign debug_enable_out    = debug_q;
    assign prot_loaded_out     = loaded;

endmodule : flash_addr_error_protect

// *** design/flash_prot_pkg.sv ***
// package: register map, field layout and carriers for the flash error/protection block
package flash_prot_pkg;

    localparam int ADDR_W = 4;
    localparam int DATA_W = 16;

    // register indices on the plain register port
    localparam logic [3:0] REG_ADDR_LOW   = 4'h0;
    localparam logic [3:0] REG_ADDR_HIGH  = 4'h1;
    localparam logic [3:0] REG_ERROR      = 4'h2;
    localparam logic [3:0] REG_WP_FUSES   = 4'h3;
    localparam logic [3:0] REG_AP_FUSES   = 4'h4;
    localparam logic [3:0] REG_AP1_LOW    = 4'h5;
    localparam logic [3:0] REG_AP1_HIGH   = 4'h6;
    localparam logic [3:0] REG_STATUS     = 4'h7;

    // field layout
    localparam logic [15:0] ADDR_LOW_MASK  = 16'hFFFC;
    localparam logic [15:0] ADDR_HIGH_MASK = 16'h001F;
    localparam logic [15:0] WP_MASK        = 16'h03FF;
    localparam int ERR_BIT   = 0;
    localparam int ERASE_ERROR_FLAG_BIT  = 1;
    localparam int PROGRAM_ERROR_FLAG_BIT  = 2;
    localparam int OVWR_BIT  = 3;
    localparam int SEQ_BIT   = 4;
    localparam int RES_BIT   = 5;
    localparam int WPF_BIT   = 8;
    localparam logic [15:0] ERROR_MASK = 16'h013F;
    localparam int ACCESS_PROTECT_FUSE_BIT  = 0;
    localparam int DEBUG_PROTECT_FUSE_BIT  = 1;
    localparam int NUM_SECT  = 10;
    localparam int NUM_PREG  = 4;

    // reset values
    localparam logic [15:0] ZERO16     = 16'h0000;
    localparam logic [15:0] PROT_ALL   = 16'h0000;
    localparam logic [15:0] FUSE_BLANK = 16'hFFFF;

    // dummy read word and trap vector for refused protected reads
    localparam logic [15:0] DUMMY_DATA  = 16'h0000;
    localparam logic [15:0] TRAP_VECTOR = 16'h009B;

    // fault events reported by the write sequencer, one cycle each
    typedef struct packed {
        logic write_fault;
        logic erase_fail;
        logic program_fail;
        logic overwrite;
        logic bad_sequence;
        logic bad_resume;
        logic protect_prog;
    } fault_events_s;

    // one program/erase attempt presented to the protection check
    typedef struct packed {
        logic                  valid;
        logic                  is_erase;
        logic [NUM_SECT-1:0]   sectors;
        logic                  setup_ok;
    } write_req_s;

    // a data access into the flash address space
    typedef struct packed {
        logic valid;
        logic is_write;
        logic fetch_from_flash;
    } data_access_s;

    typedef enum logic [1:0] {
        LOAD_IDLE,
        LOAD_READ,
        LOAD_DONE
    } fuse_load_e;

endpackage : flash_prot_pkg

// *** design/fuse_loader.sv ***
// loader that copies the nonvolatile protection cells into volatile copies
`timescale 1ns/100ps
module fuse_loader
    import flash_prot_pkg::*;
(
    input  wire logic                     ref_clk_in,
    input  wire logic                     rst_in,
    input  wire logic [NUM_PREG*16-1:0]   nv_cells_in,
    input  wire logic                     nv_ready_in,
    input  wire logic [NUM_PREG-1:0]      set_prot_in,
    input  wire logic [15:0]              set_data_in,
    output logic      [NUM_PREG*16-1:0]   prot_regs_out,
    output logic                          loaded_out
);

    fuse_load_e            state;
    fuse_load_e            next_state;
    logic [NUM_PREG*16-1:0] regs;
    logic [NUM_PREG*16-1:0] next_regs;
    logic [1:0]            rdy_sync;
    logic                  loaded;
    logic                  next_loaded;

    // all protections read active (zero) until the cells have been read
    always_comb begin
        next_state = state;
        next_regs  = regs;
        unique case (state)
            LOAD_IDLE: next_state = LOAD_READ;
            LOAD_READ: begin
                if (rdy_sync[1]) begin
                    next_regs  = nv_cells_in;
                    next_state = LOAD_DONE;
                end
            end
            LOAD_DONE: begin
                // set protection writes the volatile copy; a 1 temporarily
                // unprotects, a 0 protects again until a later set writes a 1
                for (int i = 0; i < NUM_PREG; i++) begin
                    if (set_prot_in[i]) begin
                        next_regs[i*16 +: 16] = set_data_in;
                    end
                end
            end
        endcase
        next_loaded = (next_state == LOAD_DONE);
    end

    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            state    <= LOAD_IDLE;
            regs     <= {NUM_PREG{PROT_ALL}};
            rdy_sync <= 2'h0;
            loaded   <= 1'b0;
        end else begin
            state    <= next_state;
            regs     <= next_regs;
            rdy_sync <= {rdy_sync[0], nv_ready_in};
            loaded   <= next_loaded;
        end
    end

    assign prot_regs_out = regs;
    assign loaded_out    = loaded;

endmodule : fuse_loader

// *** testbench/flash_prot_chk.sv ***
// checker: port-level properties of the flash error/protection block
`timescale 1ns/100ps
module flash_prot_chk
    import flash_prot_pkg::*;
(
    input  wire logic                ref_clk_in,
    input  wire logic                rst_in,
    input  wire logic [ADDR_W-1:0]   reg_addr_in,
    input  wire logic                reg_read_in,
    input  wire logic [DATA_W-1:0]   reg_rdata_out,
    input  wire fault_events_s       faults_in,
    input  wire write_req_s          write_req_in,
    input  wire logic                suspend_active_in,
    input  wire data_access_s        access_in,
    input  wire logic [NUM_SECT-1:0] sector_go_out,
    input  wire logic                write_go_out,
    input  wire logic                abort_suspended_out,
    input  wire logic                access_block_out,
    input  wire logic                trap_out,
    input  wire logic [15:0]         trap_vector_out,
    input  wire logic                debug_enable_out,
    input  wire logic                prot_loaded_out
);
    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (rst_in);

    property p_trap_vec;
        trap_out |-> trap_vector_out == TRAP_VECTOR;
    endproperty
    a_trap_vec: assert property (p_trap_vec)
        else $error("trap vector wrong during trap");
    property p_trap_cause;
        trap_out |-> $past(access_in.valid && !access_in.is_write
                           && !access_in.fetch_from_flash);
    endproperty
    a_trap_cause: assert property (p_trap_cause)
        else $error("trap without an outside read");
    property p_fetch_ok;
        access_in.valid && access_in.fetch_from_flash |=> !access_block_out;
    endproperty
    a_fetch_ok: assert property (p_fetch_ok)
        else $error("access from flash fetch was blocked");
    property p_sect_sub;
        write_go_out |-> (sector_go_out & ~$past(write_req_in.sectors)) == 0;
    endproperty
    a_sect_sub: assert property (p_sect_sub)
        else $error("sector allowed that was not requested");
    property p_bad_setup;
        write_req_in.valid && !write_req_in.setup_ok |=> !write_go_out;
    endproperty
    a_bad_setup: assert property (p_bad_setup)
        else $error("write started on a bad setup");
    property p_go_cause;
        write_go_out |-> $past(write_req_in.valid && write_req_in.setup_ok);
    endproperty
    a_go_cause: assert property (p_go_cause)
        else $error("write started without a valid request");
    property p_abort;
        faults_in.bad_resume && suspend_active_in |=> abort_suspended_out;
    endproperty
    a_abort: assert property (p_abort)
        else $error("bad resume did not abort");
    property p_dbg_load;
        !prot_loaded_out |-> !debug_enable_out;
    endproperty
    a_dbg_load: assert property (p_dbg_load)
        else $error("debug enabled before fuses loaded");
    property p_loaded_hold;
        prot_loaded_out |=> prot_loaded_out [*3];
    endproperty
    a_loaded_hold: assert property (p_loaded_hold)
        else $error("loaded flag dropped");
    property p_low_bits;
        $past(reg_read_in && reg_addr_in == REG_ADDR_LOW)
            |-> reg_rdata_out[1:0] == 2'h0;
    endproperty
    a_low_bits: assert property (p_low_bits)
        else $error("reserved address bits read nonzero");
endmodule : flash_prot_chk

// *** testbench/testbench.sv ***
// self-checking bench for the flash error/protection block
`timescale 1ns/100ps
module testbench;
    import flash_prot_pkg::*;
    logic ref_clk_in, rst_in, reg_write_in, reg_read_in, bank0_busy_flag_in;
    logic suspend_active_in, set_protection_in, exec_from_flash_in;
    logic temporary_unprotect_bit_in, nv_ready_in, write_go_out;
    logic abort_suspended_out, access_block_out, trap_out;
    logic debug_enable_out, prot_loaded_out;
    logic [ADDR_W-1:0]    reg_addr_in;
    logic [15:0]          reg_wdata_in, reg_rdata_out, set_prot_data_in;
    logic [15:0]          trap_vector_out;
    logic [1:0]           set_prot_reg_in;
    logic [NUM_PREG*16-1:0] nv_cells_in;
    logic [NUM_SECT-1:0]  sector_go_out;
    fault_events_s        faults_in;
    write_req_s           write_req_in;
    data_access_s         access_in;
    int                   n_mismatch = 0;
    int                   comparisons = 0;

    flash_addr_error_protect DUT (.*);

    always #50 ref_clk_in = ~ref_clk_in;

    task test_done();
        $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
        if (n_mismatch == 0 && comparisons > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : test_done

    task chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        comparisons++;
        if (g !== e) begin
            n_mismatch++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    task wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge ref_clk_in);
        reg_addr_in  <= a;
        reg_wdata_in <= d;
        reg_write_in <= 1'b1;
        @(posedge ref_clk_in);
        reg_write_in <= 1'b0;
    endtask : wr

    task rd(input logic [3:0] a, output logic [15:0] d);
        @(posedge ref_clk_in);
        reg_addr_in <= a;
        reg_read_in <= 1'b1;
        @(posedge ref_clk_in);
        reg_read_in <= 1'b0;
        #1 d = reg_rdata_out;
    endtask : rd

    task fault(input logic [6:0] f);
        @(posedge ref_clk_in);
        faults_in <= fault_events_s'(f);
        @(posedge ref_clk_in);
        faults_in <= '0;
        #1;
    endtask : fault

    task wreq(input logic [9:0] s, input logic ok);
        @(posedge ref_clk_in);
        write_req_in <= {1'b1, 1'($urandom), s, ok};
        @(posedge ref_clk_in);
        write_req_in <= '0;
        #1;
    endtask : wreq

    task acc(input logic w, input logic ff);
        @(posedge ref_clk_in);
        access_in <= {1'b1, w, ff};
        @(posedge ref_clk_in);
        access_in <= '0;
        #1;
    endtask : acc

    task setp(input logic ff, input logic [15:0] d);
        @(posedge ref_clk_in);
        exec_from_flash_in <= ff;
        set_protection_in  <= 1'b1;
        set_prot_data_in   <= d;
        @(posedge ref_clk_in);
        set_protection_in  <= 1'b0;
    endtask : setp

    // busy falls, pending flags post, busy rises so later events stay pending
    task post();
        bank0_busy_flag_in <= 1'b0;
        repeat (6) @(posedge ref_clk_in);
        bank0_busy_flag_in <= 1'b1;
    endtask : post

    initial begin
        repeat (20000) @(posedge ref_clk_in);
        n_mismatch++;
        test_done();
    end

    initial begin
        logic [15:0] v, wp, e;
        logic [9:0]  s;
        {ref_clk_in, reg_write_in, reg_read_in, suspend_active_in} = '0;
        {set_protection_in, exec_from_flash_in, nv_ready_in} = '0;
        {temporary_unprotect_bit_in, set_prot_reg_in} = '0;
        {reg_addr_in, reg_wdata_in, set_prot_data_in} = '0;
        {faults_in, write_req_in, access_in} = '0;
        rst_in = 1'b1;
        bank0_busy_flag_in = 1'b1;
        void'($urandom(32'hCA1C1561));
        wp = 16'($urandom) & 16'hFFFE;
        nv_cells_in = {16'hFFFF, 16'hFFFF, 16'hFFFE, wp};
        repeat (2) @(posedge ref_clk_in);
        rst_in <= 1'b0;
        wreq(10'h3FF, 1'b1);
        chk("sector_go", 16'h0, sector_go_out);
        acc(1'b0, 1'b0);
        chk("access_block", 16'h1, access_block_out);
        nv_ready_in <= 1'b1;
        repeat (5) @(posedge ref_clk_in);
        #1 chk("loaded", 16'h1, prot_loaded_out);
        chk("debug", 16'h1, debug_enable_out);
        rd(REG_STATUS, e);
        chk("status", 16'h3, e);
        @(posedge ref_clk_in);
        #1 chk("rdata_idle", 16'h0, reg_rdata_out);
        post();
        rd(REG_ERROR, e);
        chk("wpf", 16'h0100, e);
        wr(REG_ERROR, 16'h0);
        for (int i = 0; i < 8; i++) begin
            v = (i == 0) ? 16'hFFFF : 16'($urandom);
            wr(REG_ADDR_LOW, v);
            wr(REG_ADDR_HIGH, ~v);
            rd(REG_ADDR_LOW, e);
            chk("addr_low", v & ADDR_LOW_MASK, e);
            rd(REG_ADDR_HIGH, e);
            chk("addr_high", ~v & ADDR_HIGH_MASK, e);
        end
        wr(REG_ADDR_LOW, 16'hFFF8);
        rd(REG_ADDR_LOW, e);
        chk("addr_dword", 16'hFFF8, e);
        wr(REG_AP_FUSES, 16'h0);
        rd(REG_AP_FUSES, e);
        chk("ap_fuses", 16'hFFFE, e);
        rd(4'hF, e);
        chk("unmapped", 16'h0, e);
        for (int i = 0; i < 7; i++) begin
            suspend_active_in <= (i == 5);
            fault((i == 6) ? 7'h09 : 7'h40 >> i);
            if (i == 5) chk("abort", 16'h1, abort_suspended_out);
            rd(REG_ERROR, e);
            chk("err_pending", 16'h0, e);
            post();
            rd(REG_ERROR, e);
            chk("err_flag", (i < 6) ? (16'h1 << i) : 16'h0, e);
            wr(REG_ERROR, 16'h0);
            rd(REG_ERROR, e);
            chk("err_clear", 16'h0, e);
        end
        fault(7'h60);
        post();
        wr(REG_ERROR, 16'hFFFE);
        rd(REG_ERROR, e);
        chk("err_keep", 16'h0002, e);
        wr(REG_ERROR, 16'h0);
        wreq(10'h001, 1'b0);
        chk("write_go", 16'h0, write_go_out);
        post();
        rd(REG_ERROR, e);
        chk("seq_err", 16'h0011, e);
        wr(REG_ERROR, 16'h0);
        for (int i = 0; i < 8; i++) begin
            s = (i == 0) ? 10'h3FF : 10'($urandom);
            wreq(s, 1'b1);
            chk("write_go", 16'h1, write_go_out);
            chk("sector_go", s & wp[9:0], sector_go_out);
        end
        post();
        rd(REG_ERROR, e);
        chk("wpf", 16'h0100, e);
        setp(1'b1, 16'hFFFF);
        wreq(10'h3FF, 1'b1);
        chk("sector_go", wp[9:0], sector_go_out);
        setp(1'b0, 16'hFFFF);
        wreq(10'h3FF, 1'b1);
        chk("sector_go", 16'h03FF, sector_go_out);
        acc(1'b0, 1'b0);
        chk("access_block", 16'h1, access_block_out);
        chk("trap", 16'h1, trap_out);
        chk("trap_vector", 16'h009B, trap_vector_out);
        acc(1'b1, 1'b0);
        chk("access_block", 16'h1, access_block_out);
        chk("trap", 16'h0, trap_out);
        acc(1'b0, 1'b1);
        chk("access_block", 16'h0, access_block_out);
        temporary_unprotect_bit_in <= 1'b1;
        repeat (4) @(posedge ref_clk_in);
        acc(1'b0, 1'b0);
        chk("access_block", 16'h0, access_block_out);
        rst_in <= 1'b1;
        repeat (2) @(posedge ref_clk_in);
        rst_in <= 1'b0;
        #1 chk("loaded", 16'h0, prot_loaded_out);
        repeat (4) @(posedge ref_clk_in);
        #1 chk("loaded", 16'h1, prot_loaded_out);
        test_done();
    end
endmodule : testbench

bind flash_addr_error_protect flash_prot_chk u_chk (
    .ref_clk_in(ref_clk_in), .rst_in(rst_in), .reg_addr_in(reg_addr_in),
    .reg_read_in(reg_read_in), .reg_rdata_out(reg_rdata_out),
    .faults_in(faults_in), .write_req_in(write_req_in),
    .suspend_active_in(suspend_active_in), .access_in(access_in),
    .sector_go_out(sector_go_out), .write_go_out(write_go_out),
    .abort_suspended_out(abort_suspended_out),
    .access_block_out(access_block_out), .trap_out(trap_out),
    .trap_vector_out(trap_vector_out), .debug_enable_out(debug_enable_out),
    .prot_loaded_out(prot_loaded_out));
